//--- rxeq_pkg.sv
package rxeq_pkg;

  // Channel count and register map of the receive block.
  localparam int          NUM_CH       = 8;
  localparam logic [1:0]  BLOCK_HI     = 2'h2;
  localparam logic [2:0]  OFS_CFG      = 3'h0;
  localparam logic [2:0]  OFS_EQ1      = 3'h3;
  localparam logic [2:0]  OFS_EQ3      = 3'h4;
  localparam logic [2:0]  OFS_GRP      = 3'h5;

  // Reset values and writable-bit masks; bit 7 and blank bits read as zero.
  localparam logic [7:0]  CFG_RST      = 8'h30;
  localparam logic [7:0]  EQ1_RST      = 8'h00;
  localparam logic [7:0]  EQ3_RST      = 8'h00;
  localparam logic [7:0]  GRP_RST      = 8'h00;
  localparam logic [7:0]  CFG_MASK     = 8'h77;
  localparam logic [7:0]  EQ1_MASK     = 8'h7f;
  localparam logic [7:0]  EQ3_MASK     = 8'h3f;
  localparam logic [7:0]  GRP_MASK     = 8'h03;

  // Field positions.
  localparam int          CFG_POL_BIT  = 6;
  localparam int          CFG_MIN_BIT  = 5;
  localparam int          CFG_EN_BIT   = 4;
  localparam int          SRC_BIT      = 6;
  localparam int          SIGN_BIT     = 5;
  localparam int          FIELD_W      = 6;
  localparam int          SET_W        = 3;
  localparam int          GRP_OVR_BIT  = 1;
  localparam int          GRP_SEL_BIT  = 0;

  // Nominal boost in units of 0.01 dB.
  localparam logic [9:0]  MINIMAL_CDB  = 10'h096;
  localparam logic [9:0]  BOARD_CDB [8] = '{10'h15e, 10'h186, 10'h1a9, 10'h1c2,
                                            10'h1db, 10'h1f4, 10'h212, 10'h226};

  // Two-wire slave framing.
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
  localparam logic [7:0]  PTR_STEP      = 8'h01;

  typedef enum logic [1:0] {SRC_PRESET, SRC_MINIMAL, SRC_DIRECT} rxeq_src_t;

  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_ADDR_ACK, S_PTR, S_PTR_ACK, S_WR, S_WR_ACK, S_RD, S_RD_ACK
  } rxeq_state_t;

endpackage

//--- rxeq_chan_decode.sv
`timescale 1ns/100ps
`default_nettype none
module rxeq_chan_decode
  import rxeq_pkg::*;
(
  // Stored channel settings.
  input  wire logic [7:0]         cfgReg,
  input  wire logic [7:0]         eq1Reg,
  input  wire logic [7:0]         eq3Reg,
  input  wire logic [7:0]         grpReg,
  // Decoded equalizer control word.
  output var  logic               polSwap,
  output var  rxeq_src_t          eqSrc,
  output var  logic               boardGroup,
  output var  logic [SET_W-1:0]   presetSet,
  output var  logic [9:0]         nominalCdb,
  output var  logic [FIELD_W-1:0] midStep,
  output var  logic [FIELD_W-1:0] highStep
);

  // Sign-magnitude field to two's complement step: sign low cuts boost.
  function automatic logic [FIELD_W-1:0] smToStep(input logic [FIELD_W-1:0] f);
    logic [FIELD_W-1:0] mag;
    mag = {1'b0, f[SIGN_BIT-1:0]};
    return f[SIGN_BIT] ? mag : (~mag + 6'h01);
  endfunction

  // Source priority: direct fields, then minimal boost, then preset tables.
  always_comb begin
    polSwap    = cfgReg[CFG_POL_BIT];
    presetSet  = cfgReg[SET_W-1:0];
    boardGroup = grpReg[GRP_OVR_BIT] ? grpReg[GRP_SEL_BIT] : 1'b1;
    midStep    = '0;
    highStep   = '0;
    nominalCdb = '0;
    if (eq1Reg[SRC_BIT]) begin
      eqSrc    = SRC_DIRECT;
      midStep  = smToStep(eq1Reg[FIELD_W-1:0]);
      highStep = smToStep(eq3Reg[FIELD_W-1:0]);
    end else if (cfgReg[CFG_MIN_BIT]) begin
      eqSrc      = SRC_MINIMAL;
      nominalCdb = MINIMAL_CDB;
    end else begin
      eqSrc = SRC_PRESET;
      if (boardGroup) begin
        nominalCdb = BOARD_CDB[presetSet];
      end
    end
  end

endmodule
`default_nettype wire

//--- rxeq_ctrl_top.sv
`timescale 1ns/100ps
`default_nettype none
module rxeq_ctrl_top
  import rxeq_pkg::*;
#(
  parameter logic [4:0] SLAVE_ADDR_HI = 5'h12
)(
  // Clock and chip reset.
  input  wire logic                           sys_clk,
  input  wire logic                           rstn,
  // Address straps.
  input  wire logic                           slave_addr_strap_low,
  input  wire logic                           slave_addr_strap_high,
  // Two-wire serial port.
  input  wire logic                           sclIn,
  input  wire logic                           sdaIn,
  output var  logic                           sdaOut,
  output var  logic                           sdaOe,
  // Per-channel equalizer control words.
  output var  logic [NUM_CH-1:0]              polaritySwap,
  output var  logic [NUM_CH-1:0][1:0]         eqSource,
  output var  logic [NUM_CH-1:0]              boardGroup,
  output var  logic [NUM_CH-1:0][SET_W-1:0]   presetBoostSetting,
  output var  logic [NUM_CH-1:0][9:0]         nominalBoostCdb,
  output var  logic [NUM_CH-1:0][FIELD_W-1:0] midBoostStep,
  output var  logic [NUM_CH-1:0][FIELD_W-1:0] highBoostStep
);

  logic              rstSync1Ff, rstSyncFf;
  logic              sclS1Ff, sclSFf, sclPrevFf, sdaS1Ff, sdaSFf, sdaPrevFf;
  logic              loS1Ff, loSFf, hiS1Ff, hiSFf, strapDoneFf;
  logic [6:0]        slaveAddrFf;
  rxeq_state_t       stateFf;
  logic [3:0]        bitCntFf;
  logic [7:0]        shiftFf, txShiftFf, ptrFf, rdByte;
  logic              rwFf, nackFf, sdaOeFf, sdaOutFf;
  logic              sclRise, sclFall, startCond, stopCond, wrStb, byteDone;
  logic [7:0]        cfgRegFf [NUM_CH];
  logic [7:0]        eq1RegFf [NUM_CH];
  logic [7:0]        eq3RegFf [NUM_CH];
  logic [7:0]        grpRegFf [NUM_CH];
  logic [NUM_CH-1:0] decPol, decBoard;
  rxeq_src_t         decSrc [NUM_CH];
  logic [SET_W-1:0]  decSet [NUM_CH];
  logic [9:0]        decCdb [NUM_CH];
  logic [FIELD_W-1:0] decMid [NUM_CH];
  logic [FIELD_W-1:0] decHigh [NUM_CH];

  // Reset asserts at once and releases through two flip-flops.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rstSync1Ff <= 1'b0;
      rstSyncFf  <= 1'b0;
    end else begin
      rstSync1Ff <= 1'b1;
      rstSyncFf  <= rstSync1Ff;
    end
  end

  // Pin synchronisers; only the second stage and later are read by logic.
  always_ff @(posedge sys_clk or negedge rstSyncFf) begin
    if (!rstSyncFf) begin
      {sclS1Ff, sclSFf, sclPrevFf} <= 3'h7;
      {sdaS1Ff, sdaSFf, sdaPrevFf} <= 3'h7;
    end else begin
      sclS1Ff   <= sclIn;
      sclSFf    <= sclS1Ff;
      sclPrevFf <= sclSFf;
      sdaS1Ff   <= sdaIn;
      sdaSFf    <= sdaS1Ff;
      sdaPrevFf <= sdaSFf;
    end
  end

  // Strap synchronisers run through reset, so they hold settled levels at release.
  always_ff @(posedge sys_clk) begin
    loS1Ff <= slave_addr_strap_low;
    loSFf  <= loS1Ff;
    hiS1Ff <= slave_addr_strap_high;
    hiSFf  <= hiS1Ff;
  end

  // Straps are caught once after reset release.
  always_ff @(posedge sys_clk or negedge rstSyncFf) begin
    if (!rstSyncFf) begin
      strapDoneFf <= 1'b0;
      slaveAddrFf <= '0;
    end else if (!strapDoneFf) begin
      strapDoneFf <= 1'b1;
      slaveAddrFf <= {SLAVE_ADDR_HI, hiSFf, loSFf};
    end
  end

  // Bus events seen at the system clock.
  assign sclRise   = sclSFf & ~sclPrevFf;
  assign sclFall   = ~sclSFf & sclPrevFf;
  assign startCond = sclSFf & sclPrevFf & sdaPrevFf & ~sdaSFf;
  assign stopCond  = sclSFf & sclPrevFf & ~sdaPrevFf & sdaSFf;
  assign byteDone  = (bitCntFf == BITS_PER_BYTE);
  assign wrStb     = sclFall && (stateFf == S_WR) && byteDone;

  // Read data for the current pointer; unmapped addresses read zero.
  always_comb begin
    rdByte = 8'h00;
    if (ptrFf[7:6] == BLOCK_HI) begin
      case (ptrFf[2:0])
        OFS_CFG: rdByte = cfgRegFf[ptrFf[5:3]];
        OFS_EQ1: rdByte = eq1RegFf[ptrFf[5:3]];
        OFS_EQ3: rdByte = eq3RegFf[ptrFf[5:3]];
        OFS_GRP: rdByte = grpRegFf[ptrFf[5:3]];
        default: rdByte = 8'h00;
      endcase
    end
  end

  // Slave protocol: bits are taken on SCL rise, SDA is changed after SCL fall.
  always_ff @(posedge sys_clk or negedge rstSyncFf) begin
    if (!rstSyncFf) begin
      stateFf   <= S_IDLE;
      bitCntFf  <= '0;
      shiftFf   <= '0;
      txShiftFf <= '0;
      ptrFf     <= '0;
      rwFf      <= 1'b0;
      nackFf    <= 1'b0;
      sdaOeFf   <= 1'b0;
    end else if (startCond) begin
      stateFf  <= S_ADDR;
      bitCntFf <= '0;
      sdaOeFf  <= 1'b0;
    end else if (stopCond) begin
      stateFf <= S_IDLE;
      sdaOeFf <= 1'b0;
    end else if (sclRise) begin
      case (stateFf)
        S_ADDR, S_PTR, S_WR: begin
          shiftFf  <= {shiftFf[6:0], sdaSFf};
          bitCntFf <= bitCntFf + 4'h1;
        end
        S_RD:     bitCntFf <= bitCntFf + 4'h1;
        S_RD_ACK: nackFf <= sdaSFf;
        default:  nackFf <= nackFf;
      endcase
    end else if (sclFall) begin
      case (stateFf)
        S_ADDR: begin
          if (byteDone) begin
            bitCntFf <= '0;
            rwFf     <= shiftFf[0];
            sdaOeFf  <= (shiftFf[7:1] == slaveAddrFf);
            stateFf  <= (shiftFf[7:1] == slaveAddrFf) ? S_ADDR_ACK : S_IDLE;
          end
        end
        S_ADDR_ACK, S_RD_ACK: begin
          bitCntFf <= '0;
          if ((stateFf == S_RD_ACK) && nackFf) begin
            sdaOeFf <= 1'b0;
            stateFf <= S_IDLE;
          end else if (rwFf) begin
            txShiftFf <= rdByte;
            sdaOeFf   <= ~rdByte[7];
            stateFf   <= S_RD;
          end else begin
            sdaOeFf <= 1'b0;
            stateFf <= S_PTR;
          end
        end
        S_PTR, S_WR: begin
          if (byteDone) begin
            bitCntFf <= '0;
            sdaOeFf  <= 1'b1;
            if (stateFf == S_PTR) begin
              ptrFf   <= shiftFf;
              stateFf <= S_PTR_ACK;
            end else begin
              ptrFf   <= ptrFf + PTR_STEP;
              stateFf <= S_WR_ACK;
            end
          end
        end
        S_PTR_ACK, S_WR_ACK: begin
          sdaOeFf <= 1'b0;
          stateFf <= S_WR;
        end
        S_RD: begin
          if (byteDone) begin
            sdaOeFf <= 1'b0;
            ptrFf   <= ptrFf + PTR_STEP;
            stateFf <= S_RD_ACK;
          end else begin
            txShiftFf <= {txShiftFf[6:0], 1'b0};
            sdaOeFf   <= ~txShiftFf[6];
          end
        end
        default: stateFf <= S_IDLE;
      endcase
    end
  end

  // Open-drain data line only ever pulls low.
  always_ff @(posedge sys_clk or negedge rstSyncFf) begin
    if (!rstSyncFf) begin
      sdaOutFf <= 1'b0;
    end else begin
      sdaOutFf <= 1'b0;
    end
  end
  assign sdaOut = sdaOutFf;
  assign sdaOe  = sdaOeFf;

  // Per-channel register file, written at the end of each data byte.
  always_ff @(posedge sys_clk or negedge rstSyncFf) begin
    if (!rstSyncFf) begin
      for (int i = 0; i < NUM_CH; i++) begin
        cfgRegFf[i] <= CFG_RST;
        eq1RegFf[i] <= EQ1_RST;
        eq3RegFf[i] <= EQ3_RST;
        grpRegFf[i] <= GRP_RST;
      end
    end else if (wrStb && (ptrFf[7:6] == BLOCK_HI)) begin
      case (ptrFf[2:0])
        OFS_CFG: cfgRegFf[ptrFf[5:3]] <= shiftFf & CFG_MASK;
        OFS_EQ1: eq1RegFf[ptrFf[5:3]] <= shiftFf & EQ1_MASK;
        OFS_EQ3: eq3RegFf[ptrFf[5:3]] <= shiftFf & EQ3_MASK;
        OFS_GRP: grpRegFf[ptrFf[5:3]] <= shiftFf & GRP_MASK;
        default: cfgRegFf[0] <= cfgRegFf[0];
      endcase
    end
  end

  // One decoder per receive channel.
  for (genvar g = 0; g < NUM_CH; g++) begin : gChan
    rxeq_chan_decode uDec (
      .cfgReg     (cfgRegFf[g]),
      .eq1Reg     (eq1RegFf[g]),
      .eq3Reg     (eq3RegFf[g]),
      .grpReg     (grpRegFf[g]),
      .polSwap    (decPol[g]),
      .eqSrc      (decSrc[g]),
      .boardGroup (decBoard[g]),
      .presetSet  (decSet[g]),
      .nominalCdb (decCdb[g]),
      .midStep    (decMid[g]),
      .highStep   (decHigh[g])
    );

    // Decoded words are registered before they leave the block.
    always_ff @(posedge sys_clk or negedge rstSyncFf) begin
      if (!rstSyncFf) begin
        polaritySwap[g]       <= 1'b0;
        eqSource[g]           <= SRC_PRESET;
        boardGroup[g]         <= 1'b1;
        presetBoostSetting[g] <= '0;
        nominalBoostCdb[g]    <= '0;
        midBoostStep[g]       <= '0;
        highBoostStep[g]      <= '0;
      end else begin
        polaritySwap[g]       <= decPol[g];
        eqSource[g]           <= decSrc[g];
        boardGroup[g]         <= decBoard[g];
        presetBoostSetting[g] <= decSet[g];
        nominalBoostCdb[g]    <= decCdb[g];
        midBoostStep[g]       <= decMid[g];
        highBoostStep[g]      <= decHigh[g];
      end
    end

    a_pol_follows: assert property (@(posedge sys_clk) disable iff (!rstSyncFf)
      ##1 polaritySwap[g] == $past(cfgRegFf[g][CFG_POL_BIT]))
      else $error("polarity swap does not follow its bit");
    a_group_default: assert property (@(posedge sys_clk) disable iff (!rstSyncFf)
      !grpRegFf[g][GRP_OVR_BIT] |=> boardGroup[g])
      else $error("board group not used without override");
    a_group_pick: assert property (@(posedge sys_clk) disable iff (!rstSyncFf)
      grpRegFf[g][GRP_OVR_BIT] |=> boardGroup[g] == $past(grpRegFf[g][GRP_SEL_BIT]))
      else $error("group override choice ignored");
    a_minimal_boost: assert property (@(posedge sys_clk) disable iff (!rstSyncFf)
      (cfgRegFf[g][CFG_MIN_BIT] && !eq1RegFf[g][SRC_BIT])
      |=> (eqSource[g] == SRC_MINIMAL) && (nominalBoostCdb[g] == MINIMAL_CDB))
      else $error("minimal boost not applied");
    a_direct_wins: assert property (@(posedge sys_clk) disable iff (!rstSyncFf)
      eq1RegFf[g][SRC_BIT] |=> eqSource[g] == SRC_DIRECT)
      else $error("direct source bit did not take priority");
    a_sign_mag: assert property (@(posedge sys_clk) disable iff (!rstSyncFf)
      eq1RegFf[g][SRC_BIT] |=> $signed(midBoostStep[g]) ==
        ($past(eq1RegFf[g][SIGN_BIT]) ? 7'sd1 : -7'sd1) * $signed({2'b00, $past(eq1RegFf[g][4:0])}))
      else $error("direct mid field decoded wrongly");
    a_preset_pick: assert property (@(posedge sys_clk) disable iff (!rstSyncFf)
      (!eq1RegFf[g][SRC_BIT] && !cfgRegFf[g][CFG_MIN_BIT] && decBoard[g])
      |=> nominalBoostCdb[g] == BOARD_CDB[$past(cfgRegFf[g][2:0])])
      else $error("preset boost not selected");
  end

  // Address byte that matches the strapped address, then the acknowledge.
  sequence s_addrMatch;
    sclFall && (stateFf == S_ADDR) && byteDone && (shiftFf[7:1] == slaveAddrFf);
  endsequence
  sequence s_ackDriven;
    sdaOeFf && (stateFf == S_ADDR_ACK);
  endsequence

  a_addr_ack: assert property (@(posedge sys_clk) disable iff (!rstSyncFf)
    s_addrMatch |=> s_ackDriven)
    else $error("no acknowledge for own address");
  a_strap_addr: assert property (@(posedge sys_clk) disable iff (!rstSyncFf)
    $rose(strapDoneFf) |-> slaveAddrFf[1:0] == {$past(hiSFf), $past(loSFf)})
    else $error("slave address straps misplaced");
  a_chan_write: assert property (@(posedge sys_clk) disable iff (!rstSyncFf)
    (wrStb && ptrFf[7:6] == BLOCK_HI && ptrFf[2:0] == OFS_EQ3)
    |=> eq3RegFf[$past(ptrFf[5:3])] == ($past(shiftFf) & EQ3_MASK))
    else $error("channel register write lost");
  a_reset_hold: assert property (@(posedge sys_clk)
    !rstn |-> !rstSyncFf && (cfgRegFf[0] == CFG_RST) && (stateFf == S_IDLE))
    else $error("logic not held in reset");

endmodule
`default_nettype wire

//--- rxeq_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module rxeq_host_model (
  // Data line as driven by the block.
  input  wire logic sdaOut,
  input  wire logic sdaOe,
  // Host-driven link pins.
  output var  logic sclIn,
  output wire logic sdaIn
);
  logic pullLow;

  // The pull-up holds the line high unless a party pulls it low.
  assign sdaIn = (sdaOe ? sdaOut : 1'b1) & ~pullLow;

  // The link clock stands high between frames.
  initial begin
    sclIn = 1'b1;
    pullLow = 1'b0;
  end

  // One bit: drive in the low phase, sample just before the fall.
  task automatic bit_io(input logic b, input int lowNs, output logic s);
    #10 pullLow = ~b;
    #(lowNs - 10) sclIn = 1'b1;
    #38 s = sdaIn;
    #2 sclIn = 1'b0;
  endtask

  // Start, or repeated start: SDA falls while SCL is high.
  task automatic start_cond();
    #10 pullLow = 1'b0;
    #60 sclIn = 1'b1;
    #40 pullLow = 1'b1;
    #40 sclIn = 1'b0;
  endtask

  // Stop: SDA rises while SCL is high, then the link rests.
  task automatic stop_cond();
    #10 pullLow = 1'b1;
    #60 sclIn = 1'b1;
    #40 pullLow = 1'b0;
    #40;
  endtask

  // Byte MSB first; a long low phase lets the block move SDA without a false start.
  task automatic xfer(input logic [7:0] b, input int lowNs, input logic ackBit,
                      output logic [7:0] r, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], (i == 7) ? 70 : lowNs, s);
      r[i] = s;
    end
    bit_io(ackBit, 70, s);
    ack = ~s;
  endtask

  // Write: address, pointer, data; ok only if all were acknowledged.
  task automatic write_regs(input logic [6:0] dev, input logic [7:0] ptr,
                            input logic [7:0] d[$], output logic ok);
    logic a;
    logic [7:0] r;
    start_cond();
    xfer({dev, 1'b0}, 40, 1'b1, r, ok);
    xfer(ptr, 40, 1'b1, r, a);
    ok &= a;
    foreach (d[i]) begin
      xfer(d[i], 40, 1'b1, r, a);
      ok &= a;
    end
    stop_cond();
  endtask

  // Read: pointer write, repeated start, n bytes, the last one refused.
  task automatic read_regs(input logic [6:0] dev, input logic [7:0] ptr, input int n,
                           output logic [7:0] q[$], output logic ok);
    logic a;
    logic [7:0] r;
    q = {};
    start_cond();
    xfer({dev, 1'b0}, 40, 1'b1, r, ok);
    xfer(ptr, 40, 1'b1, r, a);
    ok &= a;
    start_cond();
    xfer({dev, 1'b1}, 40, 1'b1, r, a);
    ok &= a;
    for (int i = 0; i < n; i++) begin
      xfer(8'hff, 70, i == n - 1, r, a);
      q.push_back(r);
    end
    stop_cond();
  endtask
endmodule
`default_nettype wire

//--- rx_equalizer_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
module rx_equalizer_control_tb;
  import rxeq_pkg::*;
  localparam logic [4:0] ADR_HI = 5'h0b;  // Arbitrary upper address bits.
  localparam int LIMIT = 60000;
  localparam int BRD[8] = '{350, 390, 425, 450, 475, 500, 530, 550};
  localparam int FLD[4] = '{0, 31, 32, 63};
  logic sys_clk = 1'b0;
  logic rstn = 1'b1;
  logic [1:0] strap = 2'h1;
  logic sclIn, sdaIn, sdaOut, sdaOe, ok;
  logic [NUM_CH-1:0] polaritySwap, boardGroup;
  logic [NUM_CH-1:0][1:0] eqSource;
  logic [NUM_CH-1:0][SET_W-1:0] presetBoostSetting;
  logic [NUM_CH-1:0][9:0] nominalBoostCdb;
  logic [NUM_CH-1:0][FIELD_W-1:0] midBoostStep, highBoostStep;
  logic [7:0] rq[$];
  int cfgM[8], eq1M[8], eq3M[8], grpM[8];
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;

  // Clock of 10 ns period.
  always #5 sys_clk = ~sys_clk;

  rxeq_ctrl_top #(.SLAVE_ADDR_HI(ADR_HI)) rxeq_ctrl_top_i (
    .sys_clk(sys_clk), .rstn(rstn),
    .slave_addr_strap_low(strap[0]), .slave_addr_strap_high(strap[1]),
    .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .polaritySwap(polaritySwap), .eqSource(eqSource), .boardGroup(boardGroup),
    .presetBoostSetting(presetBoostSetting), .nominalBoostCdb(nominalBoostCdb),
    .midBoostStep(midBoostStep), .highBoostStep(highBoostStep));

  rxeq_host_model rxeq_host_model_i (
    .sdaOut(sdaOut), .sdaOe(sdaOe), .sclIn(sclIn), .sdaIn(sdaIn));

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // A hang counts as a mismatch.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fail_count++;
      $display("[FAIL] %0t timeout", $time);
      end_sim();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Signed step from a sign-magnitude field.
  function automatic logic [5:0] step(input int f);
    return f[5] ? 6'(f & 31) : 6'(-(f & 31));
  endfunction

  // Compares every channel's control word with the register model.
  task automatic check_all();
    int src, brd, nom;
    repeat (3) @(posedge sys_clk);
    #1;
    for (int c = 0; c < NUM_CH; c++) begin
      src = eq1M[c][6] ? 2 : (cfgM[c][5] ? 1 : 0);
      brd = grpM[c][1] ? grpM[c][0] : 1;
      nom = (src == 1) ? 150 : ((src == 0 && brd == 1) ? BRD[cfgM[c] & 7] : 0);
      check(16'(polaritySwap[c]), 16'(cfgM[c][6]), "polarity");
      check(16'(eqSource[c]), 16'(src), "source");
      check(16'(boardGroup[c]), 16'(brd), "group");
      check(16'(presetBoostSetting[c]), 16'(cfgM[c] & 7), "setting");
      check(16'(nominalBoostCdb[c]), 16'(nom), "boost");
      check(16'(midBoostStep[c]), 16'((src == 2) ? step(eq1M[c]) : 0), "mid");
      check(16'(highBoostStep[c]), 16'((src == 2) ? step(eq3M[c]) : 0), "high");
    end
  endtask

  // Burst write from a channel offset; the model keeps only writable bits.
  task automatic wr(input int c, input int ofs, input logic [7:0] d[$]);
    logic a;
    rxeq_host_model_i.write_regs({ADR_HI, strap}, 8'(128 + 8 * c + ofs), d, a);
    check(16'(a), 16'h1, "ack");
    foreach (d[i]) begin
      case (ofs + i)
        0: cfgM[c] = d[i] & 8'h77;
        3: eq1M[c] = d[i] & 8'h7f;
        4: eq3M[c] = d[i] & 8'h3f;
        5: grpM[c] = d[i] & 8'h03;
        default: ;
      endcase
    end
  endtask

  // Reset with the given straps; source, group and SDA drive must sit at reset values meanwhile.
  task automatic do_reset(input logic [1:0] s);
    @(posedge sys_clk);
    #1 rstn = 1'b0;
    strap = s;
    repeat (2) @(posedge sys_clk);
    #1;
    check(16'(eqSource), 16'h0, "reset source");
    check(16'(boardGroup), 16'hff, "reset group");
    check(16'(sdaOe), 16'h0, "reset drive");
    rstn = 1'b1;
    for (int c = 0; c < NUM_CH; c++) begin
      cfgM[c] = 8'h30;
      eq1M[c] = 0;
      eq3M[c] = 0;
      grpM[c] = 0;
    end
    repeat (10) @(posedge sys_clk);
  endtask

  // Main sequence.
  initial begin
    int f;
    void'($urandom(45));
    do_reset(2'h1);
    check_all();
    $display("test defaults done");
    // Four settings on every channel, all eight across the channels, unmapped offsets in the burst.
    for (int it = 0; it < 4; it++) begin
      for (int c = 0; c < NUM_CH; c++) begin
        wr(c, 0, '{8'(($urandom & 8'h70) | ((it * 3 + c) & 7)), 8'($urandom),
                   8'($urandom), 8'h00, 8'($urandom), 8'($urandom & 3)});
      end
      check_all();
    end
    rxeq_host_model_i.read_regs({ADR_HI, strap}, 8'hb8, 6, rq, ok);
    foreach (rq[i]) begin
      f = (i == 0) ? cfgM[7] : (i == 3) ? eq1M[7] : (i == 4) ? eq3M[7] : (i == 5) ? grpM[7] : 0;
      check(16'(rq[i]), 16'(f), "readback");
    end
    $display("test basic mode done");
    // Direct fields first, then the source bit; even channels also ask for minimal.
    for (int c = 0; c < NUM_CH; c++) begin
      f = (c < 4) ? FLD[c] : ($urandom & 63);
      if (c[0] == 1'b0) begin
        wr(c, 0, '{8'h27});
      end
      wr(c, 3, '{8'(f), 8'(63 - f)});
      wr(c, 3, '{8'(8'h40 | f)});
    end
    check_all();
    wr(0, 3, '{8'h00});
    check_all();
    $display("test direct mode done");
    // New straps: the old address is refused, the new one accepted.
    do_reset(2'h2);
    rxeq_host_model_i.write_regs({ADR_HI, 2'h1}, 8'h80, '{8'h47}, ok);
    check(16'(ok), 16'h0, "old address");
    wr(1, 0, '{8'h47});
    check_all();
    rxeq_host_model_i.read_regs({ADR_HI, strap}, 8'h40, 1, rq, ok);
    check(16'(rq[0]), 16'h0, "unmapped read");
    $display("test address straps done");
    end_sim();
  end
endmodule
`default_nettype wire
